// file: hw/dsr_pkg.sv
// Contract
// - NMI fires on falling pin edge only; a pin already low when system reset ends also fires it once.
// - Low reset pin overrides every other event; external readout is still taken and answered while it is low.
// - Programming level on VPP during reset selects programming.
// - Port pins are pulled-up inputs after reset.
// - Separate program, data and stack spaces.
// - Program counter is twelve bits wide.
// - Return stack holds six twelve-bit entries.
// - Readout protection refuses external program reads.
// - Data window 40h-7Fh reads program memory.
// - Port data, direction, option registers reset 00h.
// - Interrupt option and window select are write-only.
// - Converter result read-only; control resets 40h.
// - Timer registers reset 7Fh, FFh, 00h.
// - Pointers at 80h-83h, accumulator at FFh.
// - Port data read: latch for outputs, pins for inputs.
// - Window select low six bits choose block.
package dsr_pkg;
    // Widths of the three spaces.
    localparam int DATA_W = 8;
    localparam int PROG_ADDR_W = 12;
    localparam int STACK_DEPTH = 6;
    localparam int STACK_PTR_W = 3;
    localparam int WIN_SEL_W = 6;
    localparam int WIN_OFS_W = 6;

    // Data-space addresses.
    localparam logic [7:0] ADDR_POINTER_ONE = 8'h80;
    localparam logic [7:0] ADDR_POINTER_SECOND = 8'h81;
    localparam logic [7:0] ADDR_SHORT_FIRST = 8'h82;
    localparam logic [7:0] ADDR_SHORT_SECOND = 8'h83;
    localparam logic [7:0] ADDR_PORTA_DATA = 8'hc0;
    localparam logic [7:0] ADDR_PORTB_DATA = 8'hc1;
    localparam logic [7:0] ADDR_PORTA_DIR = 8'hc4;
    localparam logic [7:0] ADDR_PORTB_DIR = 8'hc5;
    localparam logic [7:0] ADDR_INT_OPTION = 8'hc8;
    localparam logic [7:0] ADDR_ROM_WIN = 8'hc9;
    localparam logic [7:0] ADDR_PORTA_OPT = 8'hcc;
    localparam logic [7:0] ADDR_PORTB_OPT = 8'hcd;
    localparam logic [7:0] ADDR_CONV_RESULT = 8'hd0;
    localparam logic [7:0] ADDR_CONV_CTRL = 8'hd1;
    localparam logic [7:0] ADDR_TMR_PRESCALE = 8'hd2;
    localparam logic [7:0] ADDR_TMR_COUNT = 8'hd3;
    localparam logic [7:0] ADDR_TMR_STATUS = 8'hd4;
    localparam logic [7:0] ADDR_WDG = 8'hd8;
    localparam logic [7:0] ADDR_ACCUM = 8'hff;
    localparam logic [1:0] WIN_ADDR_TOP = 2'h1;

    // Reset values; undefined registers come up at RST_UNDEF.
    localparam logic [7:0] RST_PORT = 8'h00;
    localparam logic [7:0] RST_CONV_CTRL = 8'h40;
    localparam logic [7:0] RST_TMR_PRESCALE = 8'h7f;
    localparam logic [7:0] RST_TMR_COUNT = 8'hff;
    localparam logic [7:0] RST_TMR_STATUS = 8'h00;
    localparam logic [7:0] RST_WDG = 8'hfe;
    localparam logic [7:0] RST_UNDEF = 8'h00;

    // Value returned for reads that have no defined content.
    localparam logic [7:0] READ_UNDEF = 8'h00;
    // Converter control bits that read back live status.
    localparam logic [7:0] CONV_CTRL_RO_MASK = 8'h40;
endpackage : dsr_pkg

// file: hw/dsr_stack_mem.sv
// Small register-file memory for return addresses; read data is registered.
module dsr_stack_mem #(
    parameter int DEPTH = 6,
    parameter int WIDTH = 12,
    parameter int PTR_W = 3
) (
    // Clock and enable.
    input wire logic i_clk,
    input wire logic i_ce,
    // Write side.
    input wire logic i_wr,
    input wire logic [PTR_W-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    // Read side.
    input wire logic i_rd,
    input wire logic [PTR_W-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);
    logic [WIDTH-1:0] mem_reg [DEPTH];

    // Entries are data only, so they carry no reset.
    always_ff @(posedge i_clk) begin
        if (i_ce && i_wr) begin
            mem_reg[i_waddr] <= i_wdata;
        end
    end

    // Registered read keeps the output glitch free.
    always_ff @(posedge i_clk) begin
        if (i_ce && i_rd) begin
            o_rdata <= mem_reg[i_raddr];
        end
    end
endmodule : dsr_stack_mem

// file: hw/dsr_port.sv
// One general-purpose port: data latch, direction and option registers.
module dsr_port #(
    parameter int W = 8,
    parameter logic [7:0] RST_VAL = 8'h00
) (
    // Clock, reset and enable.
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Register writes.
    input wire logic i_wr_data,
    input wire logic i_wr_dir,
    input wire logic i_wr_opt,
    input wire logic [W-1:0] i_wdata,
    // Pin side.
    input wire logic [W-1:0] i_pin,
    output logic [W-1:0] o_out,
    output logic [W-1:0] o_oe,
    output logic [W-1:0] o_pullup,
    // Register read-back.
    output logic [W-1:0] o_rd_data,
    output logic [W-1:0] o_dir,
    output logic [W-1:0] o_opt
);
    logic [W-1:0] data_reg;
    logic [W-1:0] dir_reg;
    logic [W-1:0] opt_reg;

    // Data latch.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            data_reg <= RST_VAL[W-1:0];
        end else if (i_ce && i_wr_data) begin
            data_reg <= i_wdata;
        end
    end

    // Direction: zero means input, so reset leaves every pin undriven.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            dir_reg <= RST_VAL[W-1:0];
        end else if (i_ce && i_wr_dir) begin
            dir_reg <= i_wdata;
        end
    end

    // Option register.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            opt_reg <= RST_VAL[W-1:0];
        end else if (i_ce && i_wr_opt) begin
            opt_reg <= i_wdata;
        end
    end

    // Per-pin drive, pull-up and read-back selection.
    for (genvar b = 0; b < W; b++) begin : g_bit
        assign o_oe[b] = dir_reg[b];
        assign o_out[b] = data_reg[b];
        assign o_pullup[b] = ~dir_reg[b] & ~opt_reg[b];
        assign o_rd_data[b] = dir_reg[b] ? data_reg[b] : i_pin[b];
    end

    assign o_dir = dir_reg;
    assign o_opt = opt_reg;

    // After reset every pin is a pulled-up input until software writes.
    port_reset_a: assert property (@(posedge i_clk)
        $fell(i_rst) |-> (o_pullup == {W{1'b1}}) && (o_oe == '0))
        else $error("port not pulled-up input after reset");

    // Input pins read live levels, output pins read the latch.
    port_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
        ((o_rd_data & ~dir_reg) == (i_pin & ~dir_reg)) &&
        ((o_rd_data & dir_reg) == (data_reg & dir_reg)))
        else $error("port read-back mixes pins wrongly");
endmodule : dsr_port

// file: hw/dsr_data_space.sv
// Data-space decoder and register bank with program window and return stack.
module dsr_data_space (
    // Clock, reset and enable.
    input wire logic I_SYS_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_CLK_EN,
    // Core data-space access.
    input wire logic [dsr_pkg::DATA_W-1:0] I_DATA_ADDR,
    input wire logic I_DATA_WR,
    input wire logic I_DATA_RD,
    input wire logic [dsr_pkg::DATA_W-1:0] I_DATA_WDATA,
    output logic [dsr_pkg::DATA_W-1:0] O_DATA_RDATA,
    output logic O_DATA_RVALID,
    // Program space.
    input wire logic [dsr_pkg::PROG_ADDR_W-1:0] I_PROG_COUNTER,
    output logic [dsr_pkg::PROG_ADDR_W-1:0] O_FETCH_ADDR,
    output logic [dsr_pkg::PROG_ADDR_W-1:0] O_PM_ADDR,
    input wire logic [dsr_pkg::DATA_W-1:0] I_PM_RDATA,
    // External readout of program memory.
    input wire logic I_EXT_RD_REQ,
    input wire logic [dsr_pkg::PROG_ADDR_W-1:0] I_EXT_RD_ADDR,
    input wire logic I_READOUT_PROTECT,
    output logic O_EXT_RD_READY,
    output logic O_EXT_RD_VALID,
    output logic O_EXT_RD_DENIED,
    output logic [dsr_pkg::DATA_W-1:0] O_EXT_RD_DATA,
    // Return stack.
    input wire logic I_STACK_PUSH,
    input wire logic I_STACK_POP,
    input wire logic [dsr_pkg::PROG_ADDR_W-1:0] I_STACK_WDATA,
    output logic [dsr_pkg::PROG_ADDR_W-1:0] O_STACK_RDATA,
    output logic [dsr_pkg::STACK_PTR_W-1:0] O_STACK_LEVEL,
    // Control pins.
    input wire logic I_NMI_PIN,
    input wire logic I_RESET_PIN_N,
    input wire logic I_VPP_HIGH,
    output logic O_NMI_REQ,
    output logic O_CORE_RESET,
    output logic O_PROG_MODE,
    // Port A pins.
    input wire logic [dsr_pkg::DATA_W-1:0] I_PORTA_PIN,
    output logic [dsr_pkg::DATA_W-1:0] O_PORTA_OUT,
    output logic [dsr_pkg::DATA_W-1:0] O_PORTA_OE,
    output logic [dsr_pkg::DATA_W-1:0] O_PORTA_PULLUP,
    // Port B pins.
    input wire logic [dsr_pkg::DATA_W-1:0] I_PORTB_PIN,
    output logic [dsr_pkg::DATA_W-1:0] O_PORTB_OUT,
    output logic [dsr_pkg::DATA_W-1:0] O_PORTB_OE,
    output logic [dsr_pkg::DATA_W-1:0] O_PORTB_PULLUP,
    // Peripheral side.
    input wire logic [dsr_pkg::DATA_W-1:0] I_CONV_RESULT,
    input wire logic [dsr_pkg::DATA_W-1:0] I_CONV_STATUS,
    output logic [dsr_pkg::DATA_W-1:0] O_INT_OPTION,
    output logic [dsr_pkg::DATA_W-1:0] O_CONV_CONTROL,
    output logic [dsr_pkg::DATA_W-1:0] O_TIMER_PRESCALE,
    output logic [dsr_pkg::DATA_W-1:0] O_TIMER_COUNT,
    output logic [dsr_pkg::DATA_W-1:0] O_TIMER_STATUS,
    output logic [dsr_pkg::DATA_W-1:0] O_WDG_VALUE
);
    import dsr_pkg::*;

    localparam logic [STACK_PTR_W-1:0] SP_LAST = STACK_PTR_W'(STACK_DEPTH - 1);
    localparam logic [STACK_PTR_W-1:0] SP_FULL = STACK_PTR_W'(STACK_DEPTH);

    logic rst_all;
    logic wr_en;
    logic win_rd;
    logic ext_take;
    logic push_en;
    logic pop_en;
    logic [DATA_W-1:0] pointer_reg [4];
    logic [DATA_W-1:0] accum_reg;
    logic [DATA_W-1:0] int_option_reg;
    logic [DATA_W-1:0] rom_win_reg;
    logic [DATA_W-1:0] conv_ctrl_reg;
    logic [DATA_W-1:0] tmr_prescale_reg;
    logic [DATA_W-1:0] tmr_count_reg;
    logic [DATA_W-1:0] tmr_status_reg;
    logic [DATA_W-1:0] wdg_reg;
    logic [DATA_W-1:0] rdata_next;
    logic [DATA_W-1:0] rdata_reg;
    logic rvalid_reg;
    logic nmi_prev_reg;
    logic nmi_req_reg;
    logic core_reset_reg;
    logic prog_mode_reg;
    logic ext_valid_reg;
    logic ext_denied_reg;
    logic [DATA_W-1:0] ext_data_reg;
    logic [STACK_PTR_W-1:0] sp_reg;
    logic [STACK_PTR_W-1:0] sp_inc;
    logic [STACK_PTR_W-1:0] sp_dec;
    logic [STACK_PTR_W-1:0] level_reg;
    logic [DATA_W-1:0] pa_rd;
    logic [DATA_W-1:0] pa_dir;
    logic [DATA_W-1:0] pa_opt;
    logic [DATA_W-1:0] pb_rd;
    logic [DATA_W-1:0] pb_dir;
    logic [DATA_W-1:0] pb_opt;

    // A low reset pin resets the bank like the system reset, except the readout and NMI logic, which see only the system reset.
    assign rst_all = I_SYS_RST || !I_RESET_PIN_N;
    assign wr_en = I_CLK_EN && I_DATA_WR;

    // Ports A and B share one implementation.
    dsr_port #(.W(DATA_W), .RST_VAL(RST_PORT)) u_port_a (
        .i_clk(I_SYS_CLK),
        .i_rst(rst_all),
        .i_ce(I_CLK_EN),
        .i_wr_data(wr_en && I_DATA_ADDR == ADDR_PORTA_DATA),
        .i_wr_dir(wr_en && I_DATA_ADDR == ADDR_PORTA_DIR),
        .i_wr_opt(wr_en && I_DATA_ADDR == ADDR_PORTA_OPT),
        .i_wdata(I_DATA_WDATA),
        .i_pin(I_PORTA_PIN),
        .o_out(O_PORTA_OUT),
        .o_oe(O_PORTA_OE),
        .o_pullup(O_PORTA_PULLUP),
        .o_rd_data(pa_rd),
        .o_dir(pa_dir),
        .o_opt(pa_opt)
    );

    dsr_port #(.W(DATA_W), .RST_VAL(RST_PORT)) u_port_b (
        .i_clk(I_SYS_CLK),
        .i_rst(rst_all),
        .i_ce(I_CLK_EN),
        .i_wr_data(wr_en && I_DATA_ADDR == ADDR_PORTB_DATA),
        .i_wr_dir(wr_en && I_DATA_ADDR == ADDR_PORTB_DIR),
        .i_wr_opt(wr_en && I_DATA_ADDR == ADDR_PORTB_OPT),
        .i_wdata(I_DATA_WDATA),
        .i_pin(I_PORTB_PIN),
        .o_out(O_PORTB_OUT),
        .o_oe(O_PORTB_OE),
        .o_pullup(O_PORTB_PULLUP),
        .o_rd_data(pb_rd),
        .o_dir(pb_dir),
        .o_opt(pb_opt)
    );

    // Core pointers and accumulator; their power-up content has no meaning.
    always_ff @(posedge I_SYS_CLK) begin
        if (rst_all) begin
            for (int i = 0; i < 4; i++) begin
                pointer_reg[i] <= RST_UNDEF;
            end
            accum_reg <= RST_UNDEF;
        end else if (wr_en) begin
            if (I_DATA_ADDR[7:2] == ADDR_POINTER_ONE[7:2]) begin
                pointer_reg[I_DATA_ADDR[1:0]] <= I_DATA_WDATA;
            end
            if (I_DATA_ADDR == ADDR_ACCUM) begin
                accum_reg <= I_DATA_WDATA;
            end
        end
    end

    // Write-only registers; software must load them before first use.
    always_ff @(posedge I_SYS_CLK) begin
        if (rst_all) begin
            int_option_reg <= RST_UNDEF;
            rom_win_reg <= RST_UNDEF;
        end else if (wr_en) begin
            if (I_DATA_ADDR == ADDR_INT_OPTION) begin
                int_option_reg <= I_DATA_WDATA;
            end
            if (I_DATA_ADDR == ADDR_ROM_WIN) begin
                rom_win_reg <= I_DATA_WDATA;
            end
        end
    end

    // Converter, timer and watchdog registers with their documented resets.
    always_ff @(posedge I_SYS_CLK) begin
        if (rst_all) begin
            conv_ctrl_reg <= RST_CONV_CTRL;
            tmr_prescale_reg <= RST_TMR_PRESCALE;
            tmr_count_reg <= RST_TMR_COUNT;
            tmr_status_reg <= RST_TMR_STATUS;
            wdg_reg <= RST_WDG;
        end else if (wr_en) begin
            unique case (I_DATA_ADDR)
                ADDR_CONV_CTRL: conv_ctrl_reg <= I_DATA_WDATA;
                ADDR_TMR_PRESCALE: tmr_prescale_reg <= I_DATA_WDATA;
                ADDR_TMR_COUNT: tmr_count_reg <= I_DATA_WDATA;
                ADDR_TMR_STATUS: tmr_status_reg <= I_DATA_WDATA;
                ADDR_WDG: wdg_reg <= I_DATA_WDATA;
                default: begin
                end
            endcase
        end
    end

    // Reads in 40h-7Fh go to program memory through the window block.
    assign win_rd = I_DATA_RD && I_DATA_ADDR[7:6] == WIN_ADDR_TOP;

    // Read mux; reserved and write-only locations return a fixed filler.
    always_comb begin
        rdata_next = READ_UNDEF;
        if (win_rd) begin
            rdata_next = I_PM_RDATA;
        end else if (I_DATA_ADDR[7:2] == ADDR_POINTER_ONE[7:2]) begin
            rdata_next = pointer_reg[I_DATA_ADDR[1:0]];
        end else begin
            unique case (I_DATA_ADDR)
                ADDR_PORTA_DATA: rdata_next = pa_rd;
                ADDR_PORTB_DATA: rdata_next = pb_rd;
                ADDR_PORTA_DIR: rdata_next = pa_dir;
                ADDR_PORTB_DIR: rdata_next = pb_dir;
                ADDR_PORTA_OPT: rdata_next = pa_opt;
                ADDR_PORTB_OPT: rdata_next = pb_opt;
                ADDR_CONV_RESULT: rdata_next = I_CONV_RESULT;
                ADDR_CONV_CTRL: rdata_next = (conv_ctrl_reg & ~CONV_CTRL_RO_MASK) |
                    (I_CONV_STATUS & CONV_CTRL_RO_MASK);
                ADDR_TMR_PRESCALE: rdata_next = tmr_prescale_reg;
                ADDR_TMR_COUNT: rdata_next = tmr_count_reg;
                ADDR_TMR_STATUS: rdata_next = tmr_status_reg;
                ADDR_WDG: rdata_next = wdg_reg;
                ADDR_ACCUM: rdata_next = accum_reg;
                default: rdata_next = READ_UNDEF;
            endcase
        end
    end

    // Read data is registered and marked valid for one enabled cycle.
    always_ff @(posedge I_SYS_CLK) begin
        if (rst_all) begin
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
        end else if (I_CLK_EN) begin
            rvalid_reg <= I_DATA_RD;
            if (I_DATA_RD) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    // The window read owns the program-memory read port; external reads wait.
    assign O_PM_ADDR = win_rd ?
        {rom_win_reg[WIN_SEL_W-1:0], I_DATA_ADDR[WIN_OFS_W-1:0]} : I_EXT_RD_ADDR;
    assign O_FETCH_ADDR = I_PROG_COUNTER;
    assign O_EXT_RD_READY = !win_rd;
    assign ext_take = I_CLK_EN && I_EXT_RD_REQ && !win_rd;

    // External readout answers next cycle, refused while protection is set.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            ext_valid_reg <= 1'b0;
            ext_denied_reg <= 1'b0;
            ext_data_reg <= '0;
        end else if (I_CLK_EN) begin
            ext_valid_reg <= ext_take && !I_READOUT_PROTECT;
            ext_denied_reg <= ext_take && I_READOUT_PROTECT;
            if (ext_take) begin
                ext_data_reg <= I_READOUT_PROTECT ? '0 : I_PM_RDATA;
            end
        end
    end

    // Falling-edge detector; a low reset pin masks the NMI entirely.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            nmi_prev_reg <= 1'b1;
            nmi_req_reg <= 1'b0;
            core_reset_reg <= 1'b1;
        end else if (I_CLK_EN) begin
            nmi_prev_reg <= I_NMI_PIN;
            nmi_req_reg <= nmi_prev_reg && !I_NMI_PIN && I_RESET_PIN_N;
            core_reset_reg <= !I_RESET_PIN_N;
        end
    end

    // Mode strap is taken while reset is active and held afterwards.
    always_ff @(posedge I_SYS_CLK) begin
        if (rst_all) begin
            prog_mode_reg <= I_VPP_HIGH;
        end
    end

    // Stack pointer wraps over six slots, so a seventh push loses the oldest.
    assign sp_inc = (sp_reg == SP_LAST) ? '0 : sp_reg + 1'b1;
    assign sp_dec = (sp_reg == '0) ? SP_LAST : sp_reg - 1'b1;
    assign push_en = I_CLK_EN && I_STACK_PUSH;
    assign pop_en = I_CLK_EN && I_STACK_POP && !I_STACK_PUSH;

    always_ff @(posedge I_SYS_CLK) begin
        if (rst_all) begin
            sp_reg <= '0;
            level_reg <= '0;
        end else if (push_en) begin
            sp_reg <= sp_inc;
            level_reg <= (level_reg == SP_FULL) ? SP_FULL : level_reg + 1'b1;
        end else if (pop_en) begin
            sp_reg <= sp_dec;
            level_reg <= (level_reg == '0) ? '0 : level_reg - 1'b1;
        end
    end

    // Stack space is its own memory, apart from program and data space.
    dsr_stack_mem #(.DEPTH(STACK_DEPTH), .WIDTH(PROG_ADDR_W), .PTR_W(STACK_PTR_W)) u_stack (
        .i_clk(I_SYS_CLK),
        .i_ce(I_CLK_EN),
        .i_wr(I_STACK_PUSH),
        .i_waddr(sp_reg),
        .i_wdata(I_STACK_WDATA),
        .i_rd(pop_en),
        .i_raddr(sp_dec),
        .o_rdata(O_STACK_RDATA)
    );

    // Output drive.
    assign O_DATA_RDATA = rdata_reg;
    assign O_DATA_RVALID = rvalid_reg;
    assign O_EXT_RD_VALID = ext_valid_reg;
    assign O_EXT_RD_DENIED = ext_denied_reg;
    assign O_EXT_RD_DATA = ext_data_reg;
    assign O_STACK_LEVEL = level_reg;
    assign O_NMI_REQ = nmi_req_reg;
    assign O_CORE_RESET = core_reset_reg;
    assign O_PROG_MODE = prog_mode_reg;
    assign O_INT_OPTION = int_option_reg;
    assign O_CONV_CONTROL = conv_ctrl_reg;
    assign O_TIMER_PRESCALE = tmr_prescale_reg;
    assign O_TIMER_COUNT = tmr_count_reg;
    assign O_TIMER_STATUS = tmr_status_reg;
    assign O_WDG_VALUE = wdg_reg;

    nmi_edge_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        (I_CLK_EN && I_NMI_PIN && I_RESET_PIN_N) ##1
        (I_CLK_EN && !I_NMI_PIN && I_RESET_PIN_N) ##1 I_CLK_EN |-> O_NMI_REQ)
        else $error("falling NMI edge not flagged");

    nmi_level_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        (I_CLK_EN && !I_NMI_PIN) [*2] ##1 I_CLK_EN |-> !O_NMI_REQ)
        else $error("NMI raised on steady low level");

    reset_prio_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        (I_CLK_EN && !I_RESET_PIN_N) |=> O_CORE_RESET && !O_NMI_REQ)
        else $error("reset pin did not take priority");

    prog_strap_a: assert property (@(posedge I_SYS_CLK)
        $fell(rst_all) |-> O_PROG_MODE == $past(I_VPP_HIGH))
        else $error("mode strap not captured at reset");

    protect_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        (ext_take && I_READOUT_PROTECT) |=> O_EXT_RD_DENIED && !O_EXT_RD_VALID &&
        O_EXT_RD_DATA == '0)
        else $error("protected program read not refused");

    window_addr_a: assert property (@(posedge I_SYS_CLK) disable iff (rst_all)
        (wr_en && I_DATA_ADDR == ADDR_ROM_WIN) ##1 win_rd |->
        O_PM_ADDR[PROG_ADDR_W-1:WIN_OFS_W] == $past(I_DATA_WDATA[WIN_SEL_W-1:0]))
        else $error("window block not taken from select");

    timer_reset_a: assert property (@(posedge I_SYS_CLK)
        $fell(rst_all) |-> O_TIMER_PRESCALE == RST_TMR_PRESCALE &&
        O_TIMER_COUNT == RST_TMR_COUNT && O_TIMER_STATUS == RST_TMR_STATUS &&
        O_CONV_CONTROL == RST_CONV_CTRL)
        else $error("peripheral reset value wrong");

    reserved_read_a: assert property (@(posedge I_SYS_CLK) disable iff (rst_all)
        (I_CLK_EN && I_DATA_RD && (I_DATA_ADDR == ADDR_ROM_WIN ||
        I_DATA_ADDR == ADDR_INT_OPTION || I_DATA_ADDR[7:6] == 2'h0)) |=>
        O_DATA_RVALID && O_DATA_RDATA == READ_UNDEF)
        else $error("reserved or write-only read not filler");

    stack_lifo_a: assert property (@(posedge I_SYS_CLK) disable iff (rst_all)
        (push_en && !I_STACK_POP) ##1 (pop_en) |=> O_STACK_RDATA == $past(I_STACK_WDATA, 2))
        else $error("stack pop did not return last push");
endmodule : dsr_data_space

// file: verif/dsr_pm_model.sv
// Asynchronous program memory behind the program-space address.
module dsr_pm_model (
    // Address in, byte out.
    input wire logic [11:0] i_addr,
    output logic [7:0] o_data
);
    timeunit 1ns;
    timeprecision 100ps;
    // Upper address bits fold in, so a wrong block shows as a wrong byte.
    assign o_data = i_addr[7:0] ^ {i_addr[11:8], i_addr[11:8]};
endmodule : dsr_pm_model

// file: verif/dsr_data_space_tb.sv
module dsr_data_space_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, en, wr, rd, erq, prot, push, pop, nmi, rpn, vpp, ey, ev, ed, nq, cre, pm, rv;
    logic [7:0] addr, wd, pa, pb, cr, cs, rdat, pmd, edat, pu, oe, v, d, p, io, po;
    logic [11:0] pc, ea, sw, fa, pma, srd;
    logic [11:0] sv [7];
    logic [2:0] slv;
    int checks, bad_count;
    logic [7:0] ra [11] = '{8'hc0, 8'hc1, 8'hc4, 8'hc5, 8'hcc, 8'hcd, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd8};
    logic [7:0] re [11] = '{0, 0, 0, 0, 0, 0, 8'h40, 8'h7f, 8'hff, 8'h00, 8'hfe};
    logic [7:0] rw [12] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff, 8'hc5, 8'hcc, 8'hcd, 8'hd2, 8'hd3,
        8'hd4, 8'hd8};
    dsr_data_space dut (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_CLK_EN(en), .I_DATA_ADDR(addr),
        .I_DATA_WR(wr), .I_DATA_RD(rd), .I_DATA_WDATA(wd), .O_DATA_RDATA(rdat), .O_DATA_RVALID(rv),
        .I_PROG_COUNTER(pc), .O_FETCH_ADDR(fa), .O_PM_ADDR(pma), .I_PM_RDATA(pmd),
        .I_EXT_RD_REQ(erq), .I_EXT_RD_ADDR(ea), .I_READOUT_PROTECT(prot), .O_EXT_RD_READY(ey),
        .O_EXT_RD_VALID(ev), .O_EXT_RD_DENIED(ed), .O_EXT_RD_DATA(edat), .I_STACK_PUSH(push),
        .I_STACK_POP(pop), .I_STACK_WDATA(sw), .O_STACK_RDATA(srd), .O_STACK_LEVEL(slv),
        .I_NMI_PIN(nmi), .I_RESET_PIN_N(rpn), .I_VPP_HIGH(vpp), .O_NMI_REQ(nq), .O_CORE_RESET(cre),
        .O_PROG_MODE(pm), .I_PORTA_PIN(pa), .O_PORTA_OUT(po), .O_PORTA_OE(oe), .O_PORTA_PULLUP(pu),
        .I_PORTB_PIN(pb), .O_PORTB_OUT(), .O_PORTB_OE(), .O_PORTB_PULLUP(), .I_CONV_RESULT(cr),
        .I_CONV_STATUS(cs), .O_INT_OPTION(io), .O_CONV_CONTROL(), .O_TIMER_PRESCALE(),
        .O_TIMER_COUNT(), .O_TIMER_STATUS(), .O_WDG_VALUE());
    dsr_pm_model pmm (.i_addr(pma), .o_data(pmd));
    // Expected program byte, worked out apart from the model instance.
    function automatic logic [7:0] pmb(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], a[11:8]};
    endfunction : pmb
    task chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One bus access; the strobe drops after the taking edge, data is looked at just after it.
    task acc(input logic w, input logic [7:0] a, input logic [7:0] x);
        @(posedge clk);
        addr <= a;
        wd <= x;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
    endtask : acc
    task st(input logic u, input logic o, input logic [11:0] x);
        @(posedge clk);
        push <= u;
        pop <= o;
        sw <= x;
        @(posedge clk);
        push <= 1'b0;
        pop <= 1'b0;
        #1;
    endtask : st
    task results();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    // Free-running 10 MHz clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Guard against a hang; the tests need well under a tenth of this.
    initial begin
        #500000;
        bad_count++;
        results();
    end
    // Main sequence.
    initial begin
        void'($urandom(82293));
        {wr, rd, erq, prot, push, pop, nmi, addr, wd, pa, pb, pc, ea, sw} = '0;
        {rst, rpn, vpp, en} = 4'hf;
        cs = 8'h40;
        cr = $urandom;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        vpp <= 1'b0;
        @(posedge clk);
        #1;
        chk({pm, pu, oe}, 17'h1ff00);
        for (int i = 0; i < 11; i++) begin
            acc(0, ra[i], 0);
            chk(rdat, re[i]);
        end
        for (int i = 0; i < 12; i++) begin
            v = $urandom;
            acc(1, rw[i], v);
            acc(0, rw[i], 0);
            chk(rdat, v);
        end
        // Written first, so that a read leaking stored content would show.
        for (int i = 0; i < 4; i++) begin
            v = i == 3 ? 8'h3f : (i == 0 ? 8'hc2 : 8'hc7 + i[7:0]);
            acc(1, v, 8'h5a);
            acc(0, v, 0);
            chk({rv, rdat}, 9'h100);
        end
        chk(io, 8'h5a);
        acc(0, 8'hd0, 0);
        chk(rdat, cr);
        // A write made while the clock enable is low must be dropped.
        acc(1, 8'hff, 8'h3c);
        @(posedge clk);
        en <= 1'b0;
        acc(1, 8'hff, 8'hc3);
        @(posedge clk);
        en <= 1'b1;
        acc(0, 8'hff, 0);
        chk(rdat, 8'h3c);
        $display("register map test done");
        d = $urandom | 8'h01;
        v = $urandom;
        p = $urandom;
        acc(1, 8'hc4, d);
        acc(1, 8'hc0, v);
        pa <= p;
        acc(0, 8'hc0, 0);
        chk(rdat, (v & d) | (p & ~d));
        chk(po, v);
        // Select write and window read back to back, as the core does.
        repeat (4) begin
            v = $urandom;
            p = $urandom % 64;
            @(posedge clk);
            addr <= 8'hc9;
            wd <= v;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
            rd <= 1'b1;
            addr <= 8'h40 | p;
            @(posedge clk);
            rd <= 1'b0;
            #1;
            chk(rdat, pmb({v[5:0], p[5:0]}));
        end
        // A window read holds the program port, so an external read must wait.
        @(posedge clk);
        addr <= 8'h7f;
        rd <= 1'b1;
        erq <= 1'b1;
        #1;
        chk(ey, 1'b0);
        @(posedge clk);
        rd <= 1'b0;
        erq <= 1'b0;
        #1;
        chk({ev, ed}, 2'b00);
        for (int i = 0; i < 2; i++) begin
            sv[0] = $urandom;
            @(posedge clk);
            ea <= sv[0];
            pc <= sv[0];
            prot <= i[0];
            erq <= 1'b1;
            @(posedge clk);
            erq <= 1'b0;
            #1;
            chk({ev, ed, edat}, {!i[0], i[0], i[0] ? 8'h00 : pmb(sv[0])});
            chk(fa, sv[0]);
        end
        for (int i = 0; i < 7; i++) begin
            sv[i] = $urandom;
            st(1, 0, sv[i]);
        end
        chk(slv, 6);
        for (int i = 6; i > 0; i--) begin
            st(0, 1, 0);
            chk(srd, sv[i]);
        end
        // Push straight followed by pop returns the pushed address.
        sv[0] = $urandom;
        @(posedge clk);
        push <= 1'b1;
        sw <= sv[0];
        @(posedge clk);
        push <= 1'b0;
        pop <= 1'b1;
        @(posedge clk);
        pop <= 1'b0;
        #1;
        chk(srd, sv[0]);
        $display("window, readout and stack tests done");
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            rpn <= !i[0];
            nmi <= 1'b1;
            @(posedge clk);
            nmi <= 1'b0;
            @(posedge clk);
            #1;
            chk({cre, nq}, {i[0], !i[0]});
            @(posedge clk);
            #1;
            chk(nq, 0);
        end
        @(posedge clk);
        rpn <= 1'b1;
        acc(0, 8'hc4, 0);
        chk({rdat, pm}, 0);
        $display("control pin test done");
        results();
    end
endmodule : dsr_data_space_tb
